// ### logic/tcfg_defs.svh
// Offsets, field positions and reset value for the configuration bank
`ifndef TCFG_DEFS_SVH
`define TCFG_DEFS_SVH
`define TCFG_NUM_REGS 16
`define TCFG_ADDR_W 4
`define TCFG_DATA_W 16
`define TCFG_OFS_HDR_TRL 4'h0
`define TCFG_OFS_MODE 4'h1
`define TCFG_OFS_PAIR12 4'h2
`define TCFG_OFS_PAIR34 4'h3
`define TCFG_OFS_PAIR56 4'h4
`define TCFG_OFS_PAIR78 4'h5
`define TCFG_OFS_BUSCLK 4'h6
`define TCFG_OFS_INIT 4'h7
`define TCFG_OFS_WINDOW 4'h8
`define TCFG_OFS_LATENCY 4'h9
`define TCFG_OFS_LOOP 4'hA
`define TCFG_OFS_CONV12 4'hB
`define TCFG_OFS_CONV34 4'hC
`define TCFG_OFS_CONV56 4'hD
`define TCFG_OFS_CONV78 4'hE
`define TCFG_OFS_DIAG 4'hF
`define TCFG_RESET_VAL 16'h0000
`define TCFG_BIT_HIRES 15
`define TCFG_BIT_HITMODE 14
`define TCFG_BIT_LETRA 13
`define TCFG_BIT_FAKE 10
`define TCFG_BIT_OVLAP 9
`define TCFG_BIT_OBSPEED 6
`define TCFG_BIT_MUTE 5
`define TCFG_BIT_LOAD 0
`define TCFG_BIT_INIT_DONE 15
`define TCFG_BIT_ROSTART 3
`define TCFG_BIT_SYNC 2
`define TCFG_BIT_COMMON 1
`define TCFG_BIT_WIDE 0
`define TCFG_BIT_PLLTEST 14
`define TCFG_BIT_OPENLOOP 13
`define TCFG_BIT_INVPHASE 12
`define TCFG_BIT_RESADJ 11
`endif

// ### logic/tcfg_pkg.sv
// Types shared by the configuration bank
package tcfg_pkg;
    typedef logic [15:0] tcfg_word_t;
    typedef logic [5:0] tcfg_trim_t;
endpackage : tcfg_pkg

// ### logic/tcfg_regs.sv
// Sixteen-word configuration bank of the converter chip
`timescale 1ns/1ps
`include "tcfg_defs.svh"

// Function
// (R1) Sixteen 16-bit registers at addresses 0-15
// (R2) Host downloads registers in fixed order
// (R3) Reg0 header enables high, trailer low
// (R4) Reg1 bit15 selects high resolution
// (R5) Reg1 bits14,13 hit and edge modes
// (R6) Host writes zero to safety bits
// (R7) Fake/overlap bits ignored in common mode
// (R8) Trigger rate bits8:7, transfer rate bit6
// (R9) Reg1 bit5 mutes all stop inputs
// (R10) Reg1 bits4:1 result processing speed
// (R11) Reg1 bit0 launches converter load
// (R12) Reg2-5 high channel edges and trim
// (R13) Reg2-5 low channel edges and trim
// (R14) Reg6 bus clock delay, reference trims
// (R15) Reg7 init flag, sync range, strobe
// (R16) Reg10 diagnosis, PLL, divider controls
// (R17) Reg15 oscillator, mode and format controls
// (R18) Host zeroes diagnostic bits of reg15
// (R19) Reg8 window width, reg9 latency
// (R20) Reg11-14 two converter bytes each
module tcfg_regs
    import tcfg_pkg::*;
#(
    parameter int NUM_REGS = `TCFG_NUM_REGS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Channel setup
    output logic [7:0] header_enable,
    output logic [7:0] trailer_enable,
    output logic [7:0] falling_edge_enable,
    output logic [7:0] rising_edge_enable,
    output logic [47:0] channel_delay_trim,
    // Modes
    output logic high_resolution,
    output logic hit_mode_32,
    output logic edge_pair_mode,
    output logic [1:0] core_trim,
    output logic fake_trigger_half,
    output logic overlap_hit,
    output logic [1:0] trigger_rate,
    output logic transfer_rate,
    output logic stop_inputs_muted,
    output logic [3:0] result_speed,
    output logic converter_load_trigger,
    // Timing and PLL
    output logic [3:0] bus_clock_delay,
    output logic [11:0] reference_delay_trim,
    output logic init_done,
    output logic [8:0] sync_range,
    output logic [5:0] hit_strobe_time,
    output logic [15:0] match_window,
    output logic [15:0] match_latency,
    output logic diag_select,
    output logic pll_test,
    output logic pll_open_loop,
    output logic pll_invert_phase,
    output logic resolution_adjust,
    output logic [2:0] ref_clock_div,
    output logic [7:0] pll_fast_div,
    // Converter data
    output logic [63:0] converter_value,
    // Diagnostic and output format
    output logic [15:0] diag_word,
    output logic ring_osc_start,
    output logic sync_mode,
    output logic common_start_mode,
    output logic wide_words
);

    // ************************************************
    // Register array
    // ************************************************
    tcfg_word_t cfg [NUM_REGS];
    tcfg_word_t next_rdata;
    tcfg_word_t rd_word;
    logic load_pulse;

    // ************************************************
    // Strobe qualification
    // ************************************************
    wire logic addr_ok = 32'(reg_addr) < NUM_REGS;
    wire logic wr_hit = reg_wr && addr_ok;
    wire logic rd_hit = reg_rd && addr_ok;
    wire logic load_req = wr_hit && (reg_addr == `TCFG_OFS_MODE)
                          && reg_wdata[`TCFG_BIT_LOAD];

    // ************************************************
    // Helper functions
    // ************************************************
    // Upper or lower byte of a channel pair word
    function automatic logic [7:0] pair_half(input tcfg_word_t w, input logic upper);
        pair_half = upper ? w[15:8] : w[7:0];
    endfunction : pair_half

    // ************************************************
    // Write path
    // ************************************************
    // Every address is writable; nothing is refused
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                cfg[i] <= `TCFG_RESET_VAL; // [R1]
            end
        end else if (wr_hit) begin
            cfg[reg_addr] <= reg_wdata; // [R1]
        end
    end

    // ************************************************
    // Register words
    // ************************************************
    wire tcfg_word_t word_hdr_trl = cfg[`TCFG_OFS_HDR_TRL];
    wire tcfg_word_t word_mode = cfg[`TCFG_OFS_MODE];

    wire tcfg_word_t word_pair12 = cfg[`TCFG_OFS_PAIR12];
    wire tcfg_word_t word_pair34 = cfg[`TCFG_OFS_PAIR34];
    wire tcfg_word_t word_pair56 = cfg[`TCFG_OFS_PAIR56];
    wire tcfg_word_t word_pair78 = cfg[`TCFG_OFS_PAIR78];

    wire tcfg_word_t word_busclk = cfg[`TCFG_OFS_BUSCLK];
    wire tcfg_word_t word_init = cfg[`TCFG_OFS_INIT];
    wire tcfg_word_t word_window = cfg[`TCFG_OFS_WINDOW];
    wire tcfg_word_t word_latency = cfg[`TCFG_OFS_LATENCY];
    wire tcfg_word_t word_loop = cfg[`TCFG_OFS_LOOP];

    wire tcfg_word_t word_conv12 = cfg[`TCFG_OFS_CONV12];
    wire tcfg_word_t word_conv34 = cfg[`TCFG_OFS_CONV34];
    wire tcfg_word_t word_conv56 = cfg[`TCFG_OFS_CONV56];
    wire tcfg_word_t word_conv78 = cfg[`TCFG_OFS_CONV78];
    wire tcfg_word_t word_diag = cfg[`TCFG_OFS_DIAG];

    // ************************************************
    // Read select
    // ************************************************
    // Idle cycles read as zero so stale data never lingers on the port
    assign rd_word = (reg_addr == `TCFG_OFS_HDR_TRL) ? word_hdr_trl :
                     (reg_addr == `TCFG_OFS_MODE) ? word_mode :
                     (reg_addr == `TCFG_OFS_PAIR12) ? word_pair12 :
                     (reg_addr == `TCFG_OFS_PAIR34) ? word_pair34 :
                     (reg_addr == `TCFG_OFS_PAIR56) ? word_pair56 :
                     (reg_addr == `TCFG_OFS_PAIR78) ? word_pair78 :
                     (reg_addr == `TCFG_OFS_BUSCLK) ? word_busclk :
                     (reg_addr == `TCFG_OFS_INIT) ? word_init :
                     (reg_addr == `TCFG_OFS_WINDOW) ? word_window :
                     (reg_addr == `TCFG_OFS_LATENCY) ? word_latency :
                     (reg_addr == `TCFG_OFS_LOOP) ? word_loop :
                     (reg_addr == `TCFG_OFS_CONV12) ? word_conv12 :
                     (reg_addr == `TCFG_OFS_CONV34) ? word_conv34 :
                     (reg_addr == `TCFG_OFS_CONV56) ? word_conv56 :
                     (reg_addr == `TCFG_OFS_CONV78) ? word_conv78 :
                     word_diag;
    assign next_rdata = rd_hit ? rd_word : `TCFG_RESET_VAL;

    // ************************************************
    // Read data and load pulse
    // ************************************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
            load_pulse <= 1'b0;
        end else begin
            reg_rdata <= next_rdata; // [R1]
            load_pulse <= load_req; // [R11]
        end
    end

    // ************************************************
    // Header and trailer enables
    // ************************************************
    assign header_enable = word_hdr_trl[15:8]; // [R3]
    assign trailer_enable = word_hdr_trl[7:0]; // [R3]

    // ************************************************
    // Resolution and edge modes
    // ************************************************
    assign high_resolution = word_mode[`TCFG_BIT_HIRES]; // [R4]
    assign hit_mode_32 = word_mode[`TCFG_BIT_HITMODE]; // [R5]
    assign edge_pair_mode = word_mode[`TCFG_BIT_LETRA]; // [R5]

    // ************************************************
    // Core trim
    // ************************************************
    // Stored as written; the host keeps it at zero
    assign core_trim = word_mode[12:11];

    // ************************************************
    // Fake trigger
    // ************************************************
    // Forced low in common start mode, where it has no meaning
    assign fake_trigger_half = word_mode[`TCFG_BIT_FAKE]
                               && !common_start_mode; // [R7]

    // ************************************************
    // Overlap hit
    // ************************************************
    assign overlap_hit = word_mode[`TCFG_BIT_OVLAP]
                         && !common_start_mode; // [R7]

    // ************************************************
    // Rates and muting
    // ************************************************
    assign trigger_rate = word_mode[8:7]; // [R8]
    assign transfer_rate = word_mode[`TCFG_BIT_OBSPEED]; // [R8]
    assign stop_inputs_muted = word_mode[`TCFG_BIT_MUTE]; // [R9]
    assign result_speed = word_mode[4:1]; // [R10]

    // ************************************************
    // Converter load
    // ************************************************
    // One-cycle pulse per write with the bit set; the bit reads back
    assign converter_load_trigger = load_pulse; // [R11]

    // ************************************************
    // Channel 1
    // ************************************************
    // Lower channel of the pair sits in the low byte
    wire logic [7:0] ch1_bits = pair_half(word_pair12, 1'b0);
    assign falling_edge_enable[0] = ch1_bits[7]; // [R13]
    assign rising_edge_enable[0] = ch1_bits[6]; // [R13]
    assign channel_delay_trim[5:0] = ch1_bits[5:0]; // [R13]

    // ************************************************
    // Channel 2
    // ************************************************
    // Higher channel of the pair sits in the high byte
    wire logic [7:0] ch2_bits = pair_half(word_pair12, 1'b1);
    assign falling_edge_enable[1] = ch2_bits[7]; // [R12]
    assign rising_edge_enable[1] = ch2_bits[6]; // [R12]
    assign channel_delay_trim[11:6] = ch2_bits[5:0]; // [R12]

    // ************************************************
    // Channel 3
    // ************************************************
    // Lower channel of the pair sits in the low byte
    wire logic [7:0] ch3_bits = pair_half(word_pair34, 1'b0);
    assign falling_edge_enable[2] = ch3_bits[7]; // [R13]
    assign rising_edge_enable[2] = ch3_bits[6]; // [R13]
    assign channel_delay_trim[17:12] = ch3_bits[5:0]; // [R13]

    // ************************************************
    // Channel 4
    // ************************************************
    // Higher channel of the pair sits in the high byte
    wire logic [7:0] ch4_bits = pair_half(word_pair34, 1'b1);
    assign falling_edge_enable[3] = ch4_bits[7]; // [R12]
    assign rising_edge_enable[3] = ch4_bits[6]; // [R12]
    assign channel_delay_trim[23:18] = ch4_bits[5:0]; // [R12]

    // ************************************************
    // Channel 5
    // ************************************************
    // Lower channel of the pair sits in the low byte
    wire logic [7:0] ch5_bits = pair_half(word_pair56, 1'b0);
    assign falling_edge_enable[4] = ch5_bits[7]; // [R13]
    assign rising_edge_enable[4] = ch5_bits[6]; // [R13]
    assign channel_delay_trim[29:24] = ch5_bits[5:0]; // [R13]

    // ************************************************
    // Channel 6
    // ************************************************
    // Higher channel of the pair sits in the high byte
    wire logic [7:0] ch6_bits = pair_half(word_pair56, 1'b1);
    assign falling_edge_enable[5] = ch6_bits[7]; // [R12]
    assign rising_edge_enable[5] = ch6_bits[6]; // [R12]
    assign channel_delay_trim[35:30] = ch6_bits[5:0]; // [R12]

    // ************************************************
    // Channel 7
    // ************************************************
    // Lower channel of the pair sits in the low byte
    wire logic [7:0] ch7_bits = pair_half(word_pair78, 1'b0);
    assign falling_edge_enable[6] = ch7_bits[7]; // [R13]
    assign rising_edge_enable[6] = ch7_bits[6]; // [R13]
    assign channel_delay_trim[41:36] = ch7_bits[5:0]; // [R13]

    // ************************************************
    // Channel 8
    // ************************************************
    // Higher channel of the pair sits in the high byte
    wire logic [7:0] ch8_bits = pair_half(word_pair78, 1'b1);
    assign falling_edge_enable[7] = ch8_bits[7]; // [R12]
    assign rising_edge_enable[7] = ch8_bits[6]; // [R12]
    assign channel_delay_trim[47:42] = ch8_bits[5:0]; // [R12]

    // ************************************************
    // Bus clock and reference trims
    // ************************************************
    wire logic [5:0] ref_a_trim = word_busclk[5:0];
    wire logic [5:0] ref_b_trim = word_busclk[11:6];
    assign bus_clock_delay = word_busclk[15:12]; // [R14]
    assign reference_delay_trim = {ref_b_trim, ref_a_trim}; // [R14]

    // ************************************************
    // Initialisation and synchronous range
    // ************************************************
    assign init_done = word_init[`TCFG_BIT_INIT_DONE]; // [R15]
    assign sync_range = word_init[14:6]; // [R15]
    assign hit_strobe_time = word_init[5:0]; // [R15]

    // ************************************************
    // Trigger matching
    // ************************************************
    // Window width and latency are plain 16-bit counts
    assign match_window = word_window; // [R19]
    assign match_latency = word_latency; // [R19]

    // ************************************************
    // Diagnosis and PLL controls
    // ************************************************
    assign diag_select = word_loop[15]; // [R16]
    assign pll_test = word_loop[`TCFG_BIT_PLLTEST]; // [R16]
    assign pll_open_loop = word_loop[`TCFG_BIT_OPENLOOP]; // [R16]
    assign pll_invert_phase = word_loop[`TCFG_BIT_INVPHASE]; // [R16]
    assign resolution_adjust = word_loop[`TCFG_BIT_RESADJ]; // [R16]

    // ************************************************
    // Clock dividers
    // ************************************************
    assign ref_clock_div = word_loop[10:8]; // [R16]
    assign pll_fast_div = word_loop[7:0]; // [R16]

    // ************************************************
    // Converter values 1 and 2
    // ************************************************
    wire logic [7:0] conv2_byte = word_conv12[15:8];
    wire logic [7:0] conv1_byte = word_conv12[7:0];
    assign converter_value[15:0] = {conv2_byte, conv1_byte}; // [R20]

    // ************************************************
    // Converter values 3 and 4
    // ************************************************
    wire logic [7:0] conv4_byte = word_conv34[15:8];
    wire logic [7:0] conv3_byte = word_conv34[7:0];
    assign converter_value[31:16] = {conv4_byte, conv3_byte}; // [R20]

    // ************************************************
    // Converter values 5 and 6
    // ************************************************
    wire logic [7:0] conv6_byte = word_conv56[15:8];
    wire logic [7:0] conv5_byte = word_conv56[7:0];
    assign converter_value[47:32] = {conv6_byte, conv5_byte}; // [R20]

    // ************************************************
    // Converter values 7 and 8
    // ************************************************
    wire logic [7:0] conv8_byte = word_conv78[15:8];
    wire logic [7:0] conv7_byte = word_conv78[7:0];
    assign converter_value[63:48] = {conv8_byte, conv7_byte}; // [R20]

    // ************************************************
    // Diagnostic word
    // ************************************************
    assign diag_word = word_diag; // [R17]

    // ************************************************
    // Output format
    // ************************************************
    // Low nibble selects oscillator, timing mode and word width
    assign ring_osc_start = word_diag[`TCFG_BIT_ROSTART]; // [R17]
    assign sync_mode = word_diag[`TCFG_BIT_SYNC]; // [R17]
    assign common_start_mode = word_diag[`TCFG_BIT_COMMON]; // [R17]
    assign wide_words = word_diag[`TCFG_BIT_WIDE]; // [R17]

endmodule : tcfg_regs

// ### verif/tb_tcfg_regs.sv
// Bench for the configuration bank
`timescale 1ns/1ps
module tb_tcfg_regs
    import tcfg_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic rd_d = 1'b0, ld_d = 1'b0;
    logic reg_wr, reg_rd, converter_load_trigger, fake_trigger_half;
    logic [3:0] reg_addr;
    tcfg_word_t reg_wdata, reg_rdata, s = 16'hCDDA;
    logic [7:0] header_enable, trailer_enable, falling_edge_enable, rising_edge_enable;
    logic [47:0] channel_delay_trim;
    logic high_resolution, hit_mode_32, edge_pair_mode, overlap_hit, transfer_rate;
    logic stop_inputs_muted, init_done, diag_select, pll_test, pll_open_loop;
    logic pll_invert_phase, resolution_adjust, ring_osc_start, sync_mode;
    logic common_start_mode, wide_words;
    logic [1:0] core_trim, trigger_rate;
    logic [3:0] result_speed, bus_clock_delay;
    logic [11:0] reference_delay_trim;
    logic [8:0] sync_range;
    logic [5:0] hit_strobe_time;
    logic [2:0] ref_clock_div;
    logic [7:0] pll_fast_div;
    tcfg_word_t match_window, match_latency, diag_word;
    logic [63:0] converter_value;
    int num_errors = 0;
    int total_checks = 0;
    always #50 sys_clk = ~sys_clk;
    tcfg_host u_host (.*);
    tcfg_regs DUT (.*);
    function automatic tcfg_word_t lfsr(input tcfg_word_t v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic chk(input logic [63:0] e, g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %h vs %h", $time, e, g);
        end
    endtask : chk
    task automatic fields;
        tcfg_word_t m [16];
        m = u_host.mem;
        chk(m[0], {header_enable, trailer_enable});
        chk(m[1][10] & ~m[15][1], fake_trigger_half);
        chk(m[1][9] & ~m[15][1], overlap_hit);
        chk({m[1][15:11], m[1][8:1]}, {high_resolution, hit_mode_32, edge_pair_mode,
            core_trim, trigger_rate, transfer_rate, stop_inputs_muted, result_speed});
        chk(m[6], {bus_clock_delay, reference_delay_trim});
        chk(m[7], {init_done, sync_range, hit_strobe_time});
        chk({m[9], m[8]}, {match_latency, match_window});
        chk(m[10], {diag_select, pll_test, pll_open_loop, pll_invert_phase,
            resolution_adjust, ref_clock_div, pll_fast_div});
        chk({m[14], m[13], m[12], m[11]}, converter_value);
        chk(m[15], diag_word);
        chk(m[15][3:0], {ring_osc_start, sync_mode, common_start_mode, wide_words});
        for (int n = 0; n < 8; n++) begin
            chk(m[2 + n / 2][n % 2 * 8 +: 8], {falling_edge_enable[n], rising_edge_enable[n],
                channel_delay_trim[6 * n +: 6]});
        end
    endtask : fields
    task automatic rd_all;
        for (int a = 0; a < 16; a++) begin
            u_host.rd(4'(a));
        end
        u_host.idle(2);
        fields();
    endtask : rd_all
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    always @(posedge sys_clk) begin
        rd_d <= reg_rd;
        ld_d <= reg_wr && reg_addr == 4'h1 && reg_wdata[0];
    end
    always @(negedge sys_clk) begin
        chk(ld_d, converter_load_trigger);
        if (rd_d) begin
            chk(u_host.exp_q.pop_front(), reg_rdata);
        end
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd_all();
        $display("reset values done");
        repeat (6) begin
            for (int a = 0; a < 16; a++) begin
                s = lfsr(s);
                u_host.wr(4'(a), s);
            end
            rd_all();
        end
        $display("downloads done");
        u_host.wr(4'h1, 16'h0601);
        u_host.wr(4'h1, 16'h0001);
        u_host.wr(4'hF, 16'h0002);
        u_host.wr(4'h1, 16'h0600);
        u_host.wr(4'h0, 16'h80A5);
        rd_all();
        $display("load and mode done");
        rst_b <= 1'b0;
        u_host.mem = '{default: 16'h0000};
        u_host.idle(3);
        rst_b <= 1'b1;
        rd_all();
        $display("second reset done");
        end_of_test();
    end
endmodule : tb_tcfg_regs

// ### verif/tcfg_host.sv
// Board-side download model for the configuration bank
`timescale 1ns/1ps
module tcfg_host
    import tcfg_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [3:0] reg_addr,
    output tcfg_word_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    tcfg_word_t mem [16] = '{default: 16'h0000};
    tcfg_word_t exp_q [$];
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 22'h0;
    task automatic wr(input logic [3:0] a, input tcfg_word_t d);
        mem[a] = a == 4'h1 ? d & 16'hE7FF : a == 4'hF ? d & 16'h9F0F : d;
        reg_addr <= a;
        reg_wdata <= mem[a];
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        exp_q.push_back(mem[a]);
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask : idle
endmodule : tcfg_host

// ### verif/tcfg_regs_properties.sv
// Port assertions for the configuration bank
`timescale 1ns/1ps
module tcfg_regs_chk
    import tcfg_pkg::*;
(
    // Clock, reset and register port
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Decoded outputs
    input wire logic [7:0] header_enable,
    input wire logic [7:0] trailer_enable,
    input wire logic high_resolution,
    input wire logic converter_load_trigger,
    input wire logic common_start_mode,
    input wire logic fake_trigger_half
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire w0 = reg_wr && reg_addr == 4'h0;
    wire r0 = reg_rd && reg_addr == 4'h0;
    wire w1 = reg_wr && reg_addr == 4'h1;
    wire ld = w1 && reg_wdata[0];
    property p_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    property p_rdw; w0 ##1 r0 |=> reg_rdata == $past(reg_wdata, 2); endproperty
    property p_wr0; w0 |=> {header_enable, trailer_enable} == $past(reg_wdata); endproperty
    property p_rd0; r0 |=> reg_rdata == {header_enable, trailer_enable}; endproperty
    property p_ld; converter_load_trigger |-> $past(ld); endproperty
    property p_ld1; ld |=> converter_load_trigger; endproperty
    property p_hr; w1 |=> high_resolution == $past(reg_wdata[15]); endproperty
    property p_fk; common_start_mode |-> !fake_trigger_half; endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    a_rdw: assert property (p_rdw) else $error("read after write");
    a_wr0: assert property (p_wr0) else $error("enables");
    a_rd0: assert property (p_rd0) else $error("enables read");
    a_ld: assert property (p_ld) else $error("stray load");
    a_ld1: assert property (p_ld1) else $error("no load");
    a_hr: assert property (p_hr) else $error("resolution");
    a_fk: assert property (p_fk) else $error("fake in common");
    c_ld: cover property (converter_load_trigger);
    c_rdw: cover property (w0 ##1 r0);
    c_cm: cover property (common_start_mode);
endmodule : tcfg_regs_chk
bind tcfg_regs tcfg_regs_chk u_chk (.*);
